// >>> logic/ppb_packet_bist.v
// What this block does
// - Count rx frames or CRC errors, 32 bits
// - View register shows one counter half
// - Kind 1 counts CRC errors, 0 frames
// - Clear bit zeroes counter, self-clears
// - Frame length 1514 or 60 bytes
// - Gap 9.6 us or 0.096 us
// - Start sends counted frames or stream
// - Start bit self-clears after last frame
// - Counter runs only when rx enabled
// - Half select 0 low, 1 high
// - Three-bit code picks frame count
// - Payload PSR9 or user byte pattern
`timescale 1ns/1ps
`default_nettype none
`include "ppb_regs.vh"
module ppb_packet_bist #(
	parameter integer GAP_LONG_CYC  = `PPB_GAP_LONG_CYC,  // Long gap in cycles
	parameter integer GAP_SHORT_CYC = `PPB_GAP_SHORT_CYC  // Short gap in cycles
) (
	input  wire        core_clk_in,      // 250 MHz clock
	input  wire        sys_rst_in,       // Synchronous reset, active high
	input  wire [4:0]  reg_addr_in,      // Register address
	input  wire [15:0] reg_wdata_in,     // Write data
	input  wire        reg_wr_in,        // Write strobe
	input  wire        reg_rd_in,        // Read strobe
	output reg  [15:0] reg_rdata_out,    // Read data, cycle after strobe
	input  wire        rx_frame_end_in,  // Pulse: received frame completed
	input  wire        rx_crc_err_in,    // Level with frame end: CRC bad
	output reg  [7:0]  tx_data_out,      // Test frame byte
	output reg         tx_valid_out,     // Byte valid
	output reg         tx_last_out,      // Last byte of frame
	output wire        tx_active_out     // Transmit test running
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg        cnt_kind_r;               // 1 = CRC errors
	reg        len_sel_r;                // 1 = long frames
	reg        gap_sel_r;                // 1 = long gap
	reg        tx_start_r;               // Transmit test running
	reg        pay_kind_r;               // 1 = pseudo-random payload
	reg [7:0]  user_pat_r;               // User payload byte
	reg        rx_en_r;                  // Counter enable
	reg        half_sel_r;               // Counter view half
	reg [2:0]  cnt_code_r;               // Frame count code
	reg [31:0] evt_cnt_r;                // Event counter
	reg [23:0] frames_left_r;            // Frames still to send
	reg [15:0] byte_idx_r;               // Byte position in frame
	reg [15:0] gap_cnt_r;                // Gap cycles remaining
	reg [8:0]  prbs_r;                   // PSR9 shift register
	reg        in_gap_r;                 // Gap phase flag
	wire       wr_cfg1;                  // Write to config one
	wire       clr_hit;                  // Clear request this cycle
	wire [15:0] frame_len;               // Selected length
	wire       byte_last;                // Final byte this cycle
	reg  [23:0] code_frames;             // Frames for the code

	assign wr_cfg1   = reg_wr_in && (reg_addr_in == `PPB_OFS_CFG_ONE);
	assign clr_hit   = wr_cfg1 && reg_wdata_in[`PPB_C1_CNT_CLR];
	assign frame_len = len_sel_r ? `PPB_LEN_LONG : `PPB_LEN_SHORT;
	assign byte_last = (byte_idx_r == frame_len - 16'd1);
	assign tx_active_out = tx_start_r;

	// ----------------------------------------
	// Frame count decode
	// ----------------------------------------
	// Code 0 means stream; its value is unused
	always @* begin
		case (cnt_code_r)
			3'h1:    code_frames = 24'd1;
			3'h2:    code_frames = 24'd10;
			3'h3:    code_frames = 24'd100;
			3'h4:    code_frames = 24'd1000;
			3'h5:    code_frames = 24'd10000;
			3'h6:    code_frames = 24'd100000;
			3'h7:    code_frames = 24'd10000000;
			default: code_frames = 24'd0;
		endcase
	end

	// ----------------------------------------
	// Configuration writes
	// ----------------------------------------
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cnt_kind_r <= 1'b0;
			len_sel_r  <= 1'b0;
			gap_sel_r  <= 1'b0;
			pay_kind_r <= 1'b0;
			user_pat_r <= 8'h00;
			rx_en_r    <= 1'b0;
			half_sel_r <= 1'b0;
			cnt_code_r <= 3'h0;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `PPB_OFS_CFG_ONE) begin
				cnt_kind_r <= reg_wdata_in[`PPB_C1_CNT_KIND];
				len_sel_r  <= reg_wdata_in[`PPB_C1_LEN_SEL];
				gap_sel_r  <= reg_wdata_in[`PPB_C1_GAP_SEL];
				pay_kind_r <= reg_wdata_in[`PPB_C1_PAY_KIND];
				user_pat_r <= reg_wdata_in[7:0];
			end else if (reg_addr_in == `PPB_OFS_CFG_TWO) begin
				rx_en_r    <= reg_wdata_in[`PPB_C2_RX_EN];
				half_sel_r <= reg_wdata_in[`PPB_C2_HALF_SEL];
				cnt_code_r <= reg_wdata_in[`PPB_C2_CNT_HI:`PPB_C2_CNT_LO];
			end
		end
	end

	// ----------------------------------------
	// Receive event counter
	// ----------------------------------------
	// Clear wins over a same-cycle increment: the frame ending now
	// started before the clear, so it must not show in the new count.
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			evt_cnt_r <= 32'h0000_0000;
		end else if (clr_hit) begin
			evt_cnt_r <= 32'h0000_0000;
		end else if (rx_en_r && rx_frame_end_in) begin
			if (!cnt_kind_r || rx_crc_err_in) begin
				evt_cnt_r <= evt_cnt_r + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------
	// Transmit generator
	// ----------------------------------------
	// Writing 1 while running is ignored, so a config rewrite during a
	// test cannot restart the frame count.
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			tx_start_r    <= 1'b0;
			frames_left_r <= 24'h000000;
			byte_idx_r    <= 16'h0000;
			gap_cnt_r     <= 16'h0000;
			in_gap_r      <= 1'b0;
			prbs_r        <= 9'h1ff;
			tx_data_out   <= 8'h00;
			tx_valid_out  <= 1'b0;
			tx_last_out   <= 1'b0;
		end else if (wr_cfg1 && reg_wdata_in[`PPB_C1_TX_START] && !tx_start_r) begin
			tx_start_r    <= 1'b1;
			frames_left_r <= code_frames;
			byte_idx_r    <= 16'h0000;
			in_gap_r      <= 1'b0;
			tx_valid_out  <= 1'b0;
			tx_last_out   <= 1'b0;
		end else if (wr_cfg1 && !reg_wdata_in[`PPB_C1_TX_START]) begin
			// Software stop: writing 0 halts the test
			tx_start_r   <= 1'b0;
			tx_valid_out <= 1'b0;
			tx_last_out  <= 1'b0;
		end else if (!tx_start_r) begin
			tx_valid_out <= 1'b0;
			tx_last_out  <= 1'b0;
		end else if (in_gap_r) begin
			// Idle gap between frames
			tx_valid_out <= 1'b0;
			tx_last_out  <= 1'b0;
			if (gap_cnt_r <= 16'h0001) begin
				in_gap_r <= 1'b0;
			end else begin
				gap_cnt_r <= gap_cnt_r - 16'h0001;
			end
		end else begin
			tx_valid_out <= 1'b1;
			tx_last_out  <= byte_last;
			if (pay_kind_r) begin
				tx_data_out <= prbs_r[7:0];
				prbs_r      <= {prbs_r[7:0], prbs_r[8] ^ prbs_r[4]};
			end else begin
				tx_data_out <= user_pat_r;
			end
			if (byte_last) begin
				byte_idx_r <= 16'h0000;
				in_gap_r   <= 1'b1;
				gap_cnt_r  <= gap_sel_r ? GAP_LONG_CYC[15:0] : GAP_SHORT_CYC[15:0];
				if (cnt_code_r != 3'h0) begin
					if (frames_left_r <= 24'h000001) begin
						tx_start_r <= 1'b0;
					end
					frames_left_r <= frames_left_r - 24'h000001;
				end
			end else begin
				byte_idx_r <= byte_idx_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	// Clear bit always reads 0 since it never holds state
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`PPB_OFS_CNT_VIEW: reg_rdata_out <= half_sel_r ? evt_cnt_r[31:16]
				                                            : evt_cnt_r[15:0];
				`PPB_OFS_CFG_ONE:  reg_rdata_out <= {cnt_kind_r, 1'b0, len_sel_r, gap_sel_r,
				                                     tx_start_r, pay_kind_r, 2'b00, user_pat_r};
				`PPB_OFS_CFG_TWO:  reg_rdata_out <= {rx_en_r, half_sel_r, cnt_code_r, 11'h000};
				default:           reg_rdata_out <= 16'h0000;
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end
endmodule // ppb_packet_bist
`default_nettype wire

// >>> include/ppb_regs.vh
`ifndef PPB_REGS_VH
`define PPB_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PPB_OFS_CNT_VIEW    5'h18
`define PPB_OFS_CFG_ONE     5'h19
`define PPB_OFS_CFG_TWO     5'h1a
// ----------------------------------------
// Config one field positions
// ----------------------------------------
`define PPB_C1_CNT_KIND     15
`define PPB_C1_CNT_CLR      14
`define PPB_C1_LEN_SEL      13
`define PPB_C1_GAP_SEL      12
`define PPB_C1_TX_START     11
`define PPB_C1_PAY_KIND     10
// ----------------------------------------
// Config two field positions
// ----------------------------------------
`define PPB_C2_RX_EN        15
`define PPB_C2_HALF_SEL     14
`define PPB_C2_CNT_HI       13
`define PPB_C2_CNT_LO       11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PPB_RST_CFG_ONE     16'h0000
`define PPB_RST_CFG_TWO     16'h0000
// ----------------------------------------
// Frame lengths and gap times
// ----------------------------------------
`define PPB_LEN_LONG        16'd1514
`define PPB_LEN_SHORT       16'd60
`define PPB_GAP_LONG_NS     9600
`define PPB_GAP_SHORT_NS    96
`define PPB_CLK_NS          4
// Longest time rounds down: whole cycles that fit in the gap
`define PPB_GAP_LONG_CYC    (`PPB_GAP_LONG_NS / `PPB_CLK_NS)
`define PPB_GAP_SHORT_CYC   (`PPB_GAP_SHORT_NS / `PPB_CLK_NS)
`endif

// >>> tb/ppb_packet_bist_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ppb_packet_bist_monitor (
	input wire        core_clk_in,     // Clock
	input wire        sys_rst_in,      // Reset
	input wire [4:0]  reg_addr_in,     // Address
	input wire [15:0] reg_wdata_in,    // Write data
	input wire        reg_wr_in,       // Write strobe
	input wire        reg_rd_in,       // Read strobe
	input wire [15:0] reg_rdata_out,   // Read data
	input wire        rx_frame_end_in, // Frame end
	input wire        rx_crc_err_in,   // CRC bad
	input wire [7:0]  tx_data_out,     // Tx byte
	input wire        tx_valid_out,    // Tx valid
	input wire        tx_last_out,     // Tx last
	input wire        tx_active_out    // Tx running
);
	// Config one write and read decode
	wire c1_wr = reg_wr_in && reg_addr_in == 5'h19;
	wire c1_rd = reg_rd_in && reg_addr_in == 5'h19;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data not zero outside read");
	a_rd_unmapped: assert property (reg_rd_in && (reg_addr_in < 5'h18 || reg_addr_in > 5'h1a)
		|=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
	a_clr_self: assert property (c1_rd |=> !reg_rdata_out[14])
		else $error("clear bit read back set");
	a_start_bit: assert property (c1_rd |=> reg_rdata_out[11] == $past(tx_active_out))
		else $error("start bit differs from active");
	a_tx_start: assert property (c1_wr && reg_wdata_in[11] && !tx_active_out |=> tx_active_out)
		else $error("start write did not start");
	a_tx_stop: assert property (c1_wr && !reg_wdata_in[11] |=> !tx_active_out)
		else $error("stop write did not stop");
	a_first_byte: assert property ($rose(tx_active_out) |=> tx_valid_out)
		else $error("first byte late");
	a_last_valid: assert property (tx_last_out |-> tx_valid_out)
		else $error("last without valid");
	a_gap_min: assert property (tx_last_out |=> !tx_valid_out [*2])
		else $error("gap too short");
endmodule // ppb_packet_bist_monitor
bind ppb_packet_bist ppb_packet_bist_monitor i_mon (.core_clk_in(core_clk_in),
	.sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.rx_frame_end_in(rx_frame_end_in), .rx_crc_err_in(rx_crc_err_in),
	.tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out),
	.tx_active_out(tx_active_out));
`default_nettype wire

// >>> tb/ppb_packet_bist_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppb_packet_bist_tb_top;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fe = 1'b0, ce = 1'b0;
	logic [4:0]  addr = 5'h00;  // Register address
	logic [15:0] wd = 16'h0000; // Write data
	wire  [15:0] rdata;         // Read data
	wire  [7:0]  txd;           // Tx byte
	wire         txv, txl, txa; // Tx valid, last, active
	integer      error_cnt = 0, cmp_count = 0;
	// Clock at 250 MHz
	always #2 clk = ~clk;
	// Short gaps keep the run small; both stay at two or more idle cycles
	ppb_packet_bist #(.GAP_LONG_CYC(6), .GAP_SHORT_CYC(3)) i_ppb_packet_bist (
		.core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_frame_end_in(fe),
		.rx_crc_err_in(ce), .tx_data_out(txd), .tx_valid_out(txv), .tx_last_out(txl),
		.tx_active_out(txa));
	// ----------------------------------------
	// Bus, compare and frame tasks
	// ----------------------------------------
	task chk(input [15:0] got, input [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input [4:0] a, input [15:0] d);
		@(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
		@(posedge clk); wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rchk(input [4:0] a, input [15:0] e);
		@(posedge clk); addr <= a; rd <= 1'b1;
		@(posedge clk); rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task pulse(input c);
		@(posedge clk); fe <= 1'b1; ce <= c;
		@(posedge clk); fe <= 1'b0; ce <= 1'b0;
	endtask
	// Follows n frames: gap, first byte, length, then active after the last
	task frames(input integer n, input integer len, input integer gap, input [7:0] pat,
		input fin);
		integer f, b, g;
		for (f = 0; f < n; f++) begin
			g = 0;
			while (txv !== 1'b1 && g < 9000) begin @(posedge clk); #1 g++; end
			if (f > 0) chk(g[15:0], gap[15:0]);
			chk({8'h00, txd}, {8'h00, pat});
			b = 1;
			while (txl !== 1'b1 && b < 2000) begin @(posedge clk); #1 b++; end
			chk(b[15:0], len[15:0]);
			@(posedge clk); #1;
		end
		chk({15'h0000, txa}, {15'h0000, !fin});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		rchk(5'h19, 16'h0000);
		rchk(5'h1a, 16'h0000);
		wr_reg(5'h19, 16'hf7ff);
		rchk(5'h19, 16'hb4ff);
		wr_reg(5'h1a, 16'hffff);
		rchk(5'h1a, 16'hf800);
		wr_reg(5'h05, 16'hffff);
		rchk(5'h05, 16'h0000);
		wr_reg(5'h1a, 16'h0000);
		wr_reg(5'h19, 16'h0000);
	endtask
	task t_count;
		wr_reg(5'h1a, 16'h8000);
		pulse(1'b0); pulse(1'b1); pulse(1'b0);
		rchk(5'h18, 16'h0003);
		wr_reg(5'h19, 16'h8000);
		pulse(1'b1); pulse(1'b0);
		rchk(5'h18, 16'h0004);
		wr_reg(5'h1a, 16'hc000);
		rchk(5'h18, 16'h0000);
		wr_reg(5'h1a, 16'h0000);
		pulse(1'b1);
		wr_reg(5'h1a, 16'h8000);
		rchk(5'h18, 16'h0004);
		// A frame landing in the clearing cycle is dropped
		@(posedge clk); addr <= 5'h19; wd <= 16'hc000; wr <= 1'b1; fe <= 1'b1; ce <= 1'b1;
		@(posedge clk); wr <= 1'b0; fe <= 1'b0; ce <= 1'b0;
		rchk(5'h18, 16'h0000);
		pulse(1'b1);
		rchk(5'h18, 16'h0001);
	endtask
	task t_tx;
		wr_reg(5'h1a, 16'h0800);
		wr_reg(5'h19, 16'h085a);
		frames(1, 60, 3, 8'h5a, 1'b1);
		rchk(5'h19, 16'h005a);
		wr_reg(5'h1a, 16'h1000);
		wr_reg(5'h19, 16'h383c);
		frames(10, 1514, 6, 8'h3c, 1'b1);
		wr_reg(5'h1a, 16'h0000);
		wr_reg(5'h19, 16'h08a5);
		frames(3, 60, 3, 8'ha5, 1'b0);
		wr_reg(5'h19, 16'h0000);
		#1 chk({15'h0000, txa}, 16'h0000);
		// Pseudo-random payload starts from its all-ones seed
		wr_reg(5'h1a, 16'h0800);
		wr_reg(5'h19, 16'h0c00);
		frames(1, 60, 3, 8'hff, 1'b1);
	endtask
	task results;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_count;
		t_tx;
		results;
	end
	// Watchdog well beyond the expected run of some 15600 cycles
	initial begin
		#150000;
		error_cnt++;
		results;
	end
endmodule // ppb_packet_bist_tb_top
`default_nettype wire
